// ===== logic/pfm_mux.sv
// Pin-function multiplexer for port lines three to seven.
`timescale 1ns/1ns

// Summary of operation
// [R1] Selecting line three as analog input cuts its I/O, interrupt and pull-high.
// [R2] A direction bit per line makes it a push-pull output or a Schmitt input.
// [R3] A control register zero bit puts PWM on line four; it also clocks timer one.
// [R4] An option picks one of four oscillator uses of lines five and six.
// [R5] The internal RC frequency is fixed per variant at 4, 8 or 12 MHz.
// [R6] Line seven is input only, either active-low reset or a general input.
// [R7] Each line but seven may be a wake-up source by option.
// [R8] Each line but seven has a pull-high enable in the pull-high register.
module pfm_mux #(
   parameter logic TWO_TIMERS = 1'b1,
   parameter logic [1:0] RC_FREQ = pfm_pkg::RC_CODE_4
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Configuration options
   input wire logic [7:0] i_cfg,
   // Pads
   input wire logic [7:3] i_pin_in,
   output logic [6:3] o_pin_out,
   output logic [6:3] o_pin_oe,
   output logic [6:3] o_pull_en,
   // Peripheral hookups
   input wire logic i_pwm,
   input wire logic i_halt,
   output logic o_analog_three_sel,
   output logic o_int_in,
   output logic o_timer_one_clk,
   output logic o_wake,
   output logic o_reset_req_n,
   // Oscillator control
   output logic o_osc_xtal_en,
   output logic o_osc_erc_en,
   output logic o_osc_irc_en,
   output logic o_osc_irc_pins,
   output logic [1:0] o_rc_freq
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (RC_FREQ > pfm_pkg::RC_CODE_12) begin : g_bad_freq
      $error("RC_FREQ must select 4, 8 or 12 MHz");
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] pull;
      logic [7:0] control_register_zero;
      logic [7:0] ansel;
      logic [7:0] rdata;
      logic [6:3] pin_out;
      logic [6:3] pin_oe;
      logic [6:3] pull_en;
      logic [7:3] pin_prev;
      logic [2:0] age;
      logic an3;
      logic int_in;
      logic timer_one_clock_input;
      logic wake;
      logic rst_n;
      logic xtal;
      logic erc;
      logic irc;
      logic irc_pins;
      logic [1:0] rc_freq;
   } pfm_mux_st_t;

   pfm_mux_st_t q;
   pfm_mux_st_t d;

   logic [7:3] pin_s;
   logic [7:0] cfg;
   logic cfg_valid;
   logic [1:0] cfg_osc;
   logic cfg_res;
   logic [6:3] cfg_wake;

   pfm_sync #(
      .WIDTH(5),
      .RST_VAL(5'h1F)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_async(i_pin_in),
      .o_sync(pin_s)
   );

   pfm_strap #(
      .WIDTH(pfm_pkg::CFG_W),
      .RST_VAL(pfm_pkg::RST_CFG)
   ) u_strap (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_cfg(i_cfg),
      .o_cfg(cfg),
      .o_valid(cfg_valid)
   );

   assign cfg_osc = cfg[pfm_pkg::CFG_OSC_LSB +: 2];
   assign cfg_res = cfg[pfm_pkg::CFG_RES_BIT];
   assign cfg_wake = cfg[pfm_pkg::CFG_WAKE_LSB +: 4];

   // ************************************************************
   // Line ownership
   // ************************************************************
   // True where a line is plain digital I/O rather than an analog
   // or oscillator pin. Shared by drive, pull, read and wake.
   function automatic logic line_is_io(input int unsigned k,
                                       input logic [1:0] osc,
                                       input logic an3);
      logic r;
      r = 1'b1;
      if (k == pfm_pkg::LINE_INT) begin
         r = !an3; // see [R1]
      end else if (k == pfm_pkg::LINE_OSCILLATOR_PIN_TWO) begin
         r = (osc == pfm_pkg::PFM_OSC_RC_IO) ||
             (osc == pfm_pkg::PFM_OSC_ERC_IO); // see [R4]
      end else if (k == pfm_pkg::LINE_OSCILLATOR_PIN_ONE) begin
         r = (osc == pfm_pkg::PFM_OSC_RC_IO); // see [R4]
      end
      return r;
   endfunction

   // Masked register write: only the bits in mask change.
   function automatic logic [7:0] wmask(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic [7:0] mask);
      return (old & ~mask) | (val & mask);
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      logic io;
      logic pwm_on;
      logic [7:0] view;
      io = 1'b0;
      pwm_on = q.control_register_zero[pfm_pkg::BIT_PWM_SEL];
      view = 8'h00;
      d = q;
      d.wake = 1'b0;
      d.rdata = 8'h00;
      d.pin_prev = pin_s;
      if (q.age != pfm_pkg::AGE_FULL) begin
         d.age = q.age + 3'h1;
      end

      // Register writes.
      if (i_wr) begin
         unique case (i_addr)
            pfm_pkg::ADDR_DATA: begin
               d.data = wmask(q.data, i_wdata, pfm_pkg::MASK_IO);
            end
            pfm_pkg::ADDR_DIR: begin
               d.dir = wmask(q.dir, i_wdata, pfm_pkg::MASK_IO); // see [R2]
            end
            pfm_pkg::ADDR_PULL: begin
               d.pull = wmask(q.pull, i_wdata, pfm_pkg::MASK_IO); // see [R8]
            end
            pfm_pkg::ADDR_CONTROL_REGISTER_ZERO: begin
               d.control_register_zero = wmask(q.control_register_zero, i_wdata, pfm_pkg::MASK_CONTROL_REGISTER_ZERO);
            end
            pfm_pkg::ADDR_ANSEL: begin
               d.ansel = wmask(q.ansel, i_wdata, pfm_pkg::MASK_ANSEL);
            end
            default: begin
            end
         endcase
      end

      // Pin view: lines not owned by I/O read as zero.
      for (int unsigned k = 3; k <= 6; k++) begin
         if (line_is_io(k, cfg_osc, q.an3)) begin
            view[k] = pin_s[k];
         end
      end
      if (!cfg_res) begin
         view[pfm_pkg::LINE_RES] = pin_s[pfm_pkg::LINE_RES]; // see [R6]
      end

      // Register reads; unmapped addresses read zero.
      if (i_rd) begin
         unique case (i_addr)
            pfm_pkg::ADDR_DATA: d.rdata = q.data;
            pfm_pkg::ADDR_DIR: d.rdata = q.dir;
            pfm_pkg::ADDR_PULL: d.rdata = q.pull;
            pfm_pkg::ADDR_CONTROL_REGISTER_ZERO: d.rdata = q.control_register_zero;
            pfm_pkg::ADDR_ANSEL: d.rdata = q.ansel;
            pfm_pkg::ADDR_PIN: d.rdata = view;
            default: d.rdata = 8'h00;
         endcase
      end

      // Pad drive, pull-high and wake-up per line.
      d.an3 = q.ansel[pfm_pkg::BIT_AN3_SEL]; // see [R1]
      for (int unsigned k = 3; k <= 6; k++) begin
         io = line_is_io(k, cfg_osc, q.an3);
         d.pin_oe[k] = io && !q.dir[k]; // see [R2]
         d.pin_out[k] = q.data[k];
         d.pull_en[k] = io && q.pull[k]; // see [R8]
         if (cfg_valid && i_halt && cfg_wake[k] && io &&
             (q.age == pfm_pkg::AGE_FULL) &&
             q.pin_prev[k] && !pin_s[k]) begin
            d.wake = 1'b1; // see [R7]
         end
      end
      // PWM takes the line whatever its direction bit says.
      if (pwm_on) begin
         d.pin_oe[pfm_pkg::LINE_PWM] = 1'b1; // see [R3]
         d.pin_out[pfm_pkg::LINE_PWM] = i_pwm; // see [R3]
      end
      d.timer_one_clock_input = TWO_TIMERS && pin_s[pfm_pkg::LINE_PWM]; // see [R3]

      // An analog line holds the interrupt input idle high.
      d.int_in = q.an3 ? 1'b1 : pin_s[pfm_pkg::LINE_INT]; // see [R1]
      d.rst_n = cfg_res ? pin_s[pfm_pkg::LINE_RES] : 1'b1; // see [R6]

      // Oscillator arrangement.
      d.xtal = (cfg_osc == pfm_pkg::PFM_OSC_XTAL); // see [R4]
      d.erc = (cfg_osc == pfm_pkg::PFM_OSC_ERC_IO);
      d.irc_pins = (cfg_osc == pfm_pkg::PFM_OSC_RC_PINS);
      d.irc = (cfg_osc == pfm_pkg::PFM_OSC_RC_IO) || d.irc_pins;
      d.rc_freq = RC_FREQ; // see [R5]
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '{data: pfm_pkg::RST_DATA, dir: pfm_pkg::RST_DIR,
                pull: pfm_pkg::RST_PULL, control_register_zero: pfm_pkg::RST_CONTROL_REGISTER_ZERO,
                ansel: pfm_pkg::RST_ANSEL, rdata: 8'h00,
                pin_out: 4'h0, pin_oe: 4'h0, pull_en: 4'h0,
                pin_prev: 5'h1F, age: 3'h0, an3: 1'b0, int_in: 1'b1,
                timer_one_clock_input: 1'b0, wake: 1'b0, rst_n: 1'b1, xtal: 1'b0,
                erc: 1'b0, irc: 1'b0, irc_pins: 1'b0, rc_freq: 2'h0};
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_rdata = q.rdata;
   assign o_pin_out = q.pin_out;
   assign o_pin_oe = q.pin_oe;
   assign o_pull_en = q.pull_en;
   assign o_analog_three_sel = q.an3;
   assign o_int_in = q.int_in;
   assign o_timer_one_clk = q.timer_one_clock_input;
   assign o_wake = q.wake;
   assign o_reset_req_n = q.rst_n;
   assign o_osc_xtal_en = q.xtal;
   assign o_osc_erc_en = q.erc;
   assign o_osc_irc_en = q.irc;
   assign o_osc_irc_pins = q.irc_pins;
   assign o_rc_freq = q.rc_freq;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_settled;
      cfg_valid && (q.age == pfm_pkg::AGE_FULL);
   endsequence

   sequence s_fall_three;
      i_halt && cfg_wake[3] && !q.an3 && q.pin_prev[3] && !pin_s[3];
   endsequence

   AST_AN3_ISOLATE: assert property ( // see [R1]
      q.an3 |=> (!o_pin_oe[3] && !o_pull_en[3] && o_int_in))
      else $error("analog line three still drives, pulls or interrupts");
   AST_DIR_OUT: assert property ( // see [R2]
      (cfg_valid && !q.dir[3] && !q.an3) |=>
         (o_pin_oe[3] && o_pin_out[3] == $past(q.data[3])))
      else $error("line three output does not follow its latch");
   AST_DIR_IN: assert property ( // see [R2]
      q.dir[5] |=> !o_pin_oe[5])
      else $error("line five drives while set as input");
   AST_PWM_SEL: assert property ( // see [R3]
      q.control_register_zero[0] |=> (o_pin_oe[4] && o_pin_out[4] == $past(i_pwm)))
      else $error("line four does not carry the PWM output");
   AST_TIMER_ONE_CLOCK_INPUT_FEED: assert property ( // see [R3]
      s_settled |-> (o_timer_one_clk ==
                     (TWO_TIMERS && $past(i_pin_in[4], 3))))
      else $error("timer one clock does not follow line four");
   AST_OSC_XTAL: assert property ( // see [R4]
      (s_settled ##0 (cfg_osc == pfm_pkg::PFM_OSC_XTAL)) |=>
         (o_osc_xtal_en && !o_pin_oe[5] && !o_pin_oe[6] &&
          !o_pull_en[5] && !o_pull_en[6]))
      else $error("crystal mode leaves I/O on an oscillator line");
   AST_OSC_ERC: assert property ( // see [R4]
      (s_settled ##0 (cfg_osc == pfm_pkg::PFM_OSC_ERC_IO)) |=>
         (o_osc_erc_en && !o_pin_oe[6] && !o_pull_en[6] &&
          o_pin_oe[5] == !$past(q.dir[5])))
      else $error("external RC mode mishandles lines five and six");
   AST_RC_FREQ: assert property ( // see [R5]
      s_settled |-> ($stable(o_rc_freq) && o_rc_freq == RC_FREQ))
      else $error("internal RC frequency code moved");
   AST_RESET_PIN: assert property ( // see [R6]
      (s_settled ##0 $past(cfg_res)) |->
         (o_reset_req_n == $past(i_pin_in[7], 3)))
      else $error("reset request does not follow line seven");
   AST_GPIO_SEVEN: assert property ( // see [R6]
      (s_settled ##0 !cfg_res) |=> o_reset_req_n)
      else $error("line seven resets while set as input");
   AST_WAKE_FALL: assert property ( // see [R7]
      (s_settled ##0 s_fall_three) |=> (o_wake ##1 !o_wake))
      else $error("falling wake line three gave no single pulse");
   AST_WAKE_CAUSE: assert property ( // see [R7]
      o_wake |-> $past(i_halt))
      else $error("wake pulse without power-down");
   AST_PULL_EN: assert property ( // see [R8]
      (q.pull[3] && !q.an3) |=> o_pull_en[3])
      else $error("pull-high of line three not connected");

endmodule

// ===== logic/pfm_pkg.sv
// Shared constants for the upper port pin-function multiplexer.
package pfm_pkg;

   // ************************************************************
   // Register port geometry and map
   // ************************************************************
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_DIR = 3'h1;
   localparam logic [2:0] ADDR_PULL = 3'h2;
   localparam logic [2:0] ADDR_CONTROL_REGISTER_ZERO = 3'h3;
   localparam logic [2:0] ADDR_ANSEL = 3'h4;
   localparam logic [2:0] ADDR_PIN = 3'h5;

   // Reset values; a set direction bit makes the line an input.
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h78;
   localparam logic [7:0] RST_PULL = 8'h00;
   localparam logic [7:0] RST_CONTROL_REGISTER_ZERO = 8'h00;
   localparam logic [7:0] RST_ANSEL = 8'h00;

   // Writable bits: lines three to six, one control bit each.
   localparam logic [7:0] MASK_IO = 8'h78;
   localparam logic [7:0] MASK_CONTROL_REGISTER_ZERO = 8'h01;
   localparam logic [7:0] MASK_ANSEL = 8'h01;
   localparam int unsigned BIT_PWM_SEL = 0;
   localparam int unsigned BIT_AN3_SEL = 0;

   // ************************************************************
   // Line numbers
   // ************************************************************
   localparam int unsigned LINE_INT = 3;
   localparam int unsigned LINE_PWM = 4;
   localparam int unsigned LINE_OSCILLATOR_PIN_TWO = 5;
   localparam int unsigned LINE_OSCILLATOR_PIN_ONE = 6;
   localparam int unsigned LINE_RES = 7;

   // ************************************************************
   // Configuration option word layout
   // ************************************************************
   localparam int unsigned CFG_W = 8;
   localparam int unsigned CFG_OSC_LSB = 0;
   localparam int unsigned CFG_RES_BIT = 2;
   localparam int unsigned CFG_WAKE_LSB = 3;
   localparam logic [7:0] RST_CFG = 8'h00;

   typedef enum logic [1:0] {
      PFM_OSC_RC_IO = 2'b00,
      PFM_OSC_XTAL = 2'b01,
      PFM_OSC_RC_PINS = 2'b10,
      PFM_OSC_ERC_IO = 2'b11
   } pfm_osc_t;

   // Internal RC frequency code per variant, fixed at build time.
   localparam int unsigned RC_FREQ_4_MHZ = 4;
   localparam int unsigned RC_FREQ_8_MHZ = 8;
   localparam int unsigned RC_FREQ_12_MHZ = 12;
   localparam logic [1:0] RC_CODE_4 = 2'h0;
   localparam logic [1:0] RC_CODE_8 = 2'h1;
   localparam logic [1:0] RC_CODE_12 = 2'h2;

   // Age counter ceiling, in cycles, after which pin history is valid.
   localparam logic [2:0] AGE_FULL = 3'h4;

endpackage

// ===== logic/pfm_sync.sv
// Two-stage synchroniser for pin levels entering the system clock.
`timescale 1ns/1ns
module pfm_sync #(
   parameter int unsigned WIDTH = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } pfm_sync_st_t;

   pfm_sync_st_t q;
   pfm_sync_st_t d;

   always_comb begin
      d = q;
      d.s1 = i_async;
      d.s2 = q.s1;
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= {RST_VAL, RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign o_sync = q.s2;

endmodule

// ===== logic/pfm_strap.sv
// Captures the configuration option word once after reset release.
`timescale 1ns/1ns
module pfm_strap #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Option word
   input wire logic [WIDTH-1:0] i_cfg,
   output logic [WIDTH-1:0] o_cfg,
   output logic o_valid
);

   typedef struct packed {
      logic loaded;
      logic [WIDTH-1:0] val;
   } pfm_strap_st_t;

   pfm_strap_st_t q;
   pfm_strap_st_t d;

   // The options are fixed in the part, so a later change is ignored.
   always_comb begin
      d = q;
      if (!q.loaded) begin
         d.val = i_cfg;
         d.loaded = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= {1'b0, RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign o_cfg = q.val;
   assign o_valid = q.loaded;

endmodule

// ===== tb/pfm_mux_test.sv
// Self-checking bench for the upper port pin-function multiplexer.
`timescale 1ns/1ns
module pfm_mux_test;
   // ************************************************************
   // Stimulus, observed outputs and scoreboard
   // ************************************************************
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_cfg = 8'h00;
   logic [7:3] pad_ext = 5'h00;
   logic [7:3] i_pin_in;
   logic i_pwm = 1'b0;
   logic i_halt = 1'b0;
   logic [7:0] o_rdata;
   logic [6:3] o_pin_out;
   logic [6:3] o_pin_oe;
   logic [6:3] o_pull_en;
   logic o_analog_three_sel;
   logic o_int_in;
   logic o_timer_one_clk;
   logic o_wake;
   logic o_reset_req_n;
   logic o_osc_xtal_en;
   logic o_osc_erc_en;
   logic o_osc_irc_en;
   logic o_osc_irc_pins;
   logic [1:0] o_rc_freq;
   typedef struct {
      string name;
      int sel;
      logic [7:0] val;
   } pfm_note_t;
   pfm_note_t rq[$];
   pfm_note_t pq[$];
   int wq[$];
   int mismatches = 0;
   int check_count = 0;
   logic [7:0] lfsr = 8'h52;
   logic probe_req = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] osc_exp [4] = '{8'h09, 8'h21, 8'h0D, 8'h11};
   logic [7:0] oe_exp [4] = '{8'h0F, 8'h03, 8'h03, 8'h07};

   always #10 i_mclk = ~i_mclk;

   // A driven pad shows the block's own level, so it resolves here.
   always_comb begin
      i_pin_in[7] = pad_ext[7];
      for (int k = 3; k < 7; k++) begin
         i_pin_in[k] = o_pin_oe[k] ? o_pin_out[k] : pad_ext[k];
      end
   end

   pfm_mux #(.TWO_TIMERS(1'b1), .RC_FREQ(pfm_pkg::RC_CODE_8)) u_dut (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_cfg(i_cfg), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
      .o_pin_oe(o_pin_oe), .o_pull_en(o_pull_en), .i_pwm(i_pwm),
      .i_halt(i_halt), .o_analog_three_sel(o_analog_three_sel),
      .o_int_in(o_int_in), .o_timer_one_clk(o_timer_one_clk),
      .o_wake(o_wake), .o_reset_req_n(o_reset_req_n),
      .o_osc_xtal_en(o_osc_xtal_en), .o_osc_erc_en(o_osc_erc_en),
      .o_osc_irc_en(o_osc_irc_en), .o_osc_irc_pins(o_osc_irc_pins),
      .o_rc_freq(o_rc_freq));

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [7:0] probe_val(input int sel);
      case (sel)
         0: probe_val = {4'h0, o_pin_oe};
         1: probe_val = {4'h0, o_pin_out};
         2: probe_val = {4'h0, o_pull_en};
         3: probe_val = {3'h0, o_analog_three_sel, o_int_in,
                         o_timer_one_clk, o_wake, o_reset_req_n};
         default: probe_val = {2'h0, o_osc_xtal_en, o_osc_erc_en,
                               o_osc_irc_en, o_osc_irc_pins, o_rc_freq};
      endcase
   endfunction

   task automatic compare(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp,
                     input string nm);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      i_addr <= a;
      rq.push_back('{nm, 0, exp});
      @(posedge i_mclk);
      i_rd <= 1'b0;
   endtask

   // Waits out the three-edge pin lag before the outputs are judged.
   task automatic pr(input int sel, input logic [7:0] exp,
                     input string nm);
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (5) @(posedge i_mclk);
      probe_req <= 1'b1;
      pq.push_back('{nm, sel, exp});
      @(posedge i_mclk);
      probe_req <= 1'b0;
   endtask

   // Options are captured only after a reset, so each set needs one.
   task automatic restart(input logic [7:0] cfg, input int n);
      @(posedge i_mclk);
      i_nrst <= 1'b0;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      i_cfg <= cfg;
      repeat (n) @(posedge i_mclk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_mclk);
   endtask

   task automatic results;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // Output watcher
   // ************************************************************
   always @(posedge i_mclk) rd_seen <= i_rd;

   always @(negedge i_mclk) begin
      pfm_note_t n;
      if (rd_seen) begin
         n = rq.pop_front();
         compare(n.name, n.val, o_rdata);
      end
      if (probe_req) begin
         n = pq.pop_front();
         compare(n.name, n.val, probe_val(n.sel));
      end
      if (o_wake === 1'b1) begin
         if (wq.size() == 0) begin
            compare("wake", 8'h00, 8'h01);
         end else begin
            void'(wq.pop_front());
            check_count++;
         end
      end
   end

   initial begin
      repeat (5000) @(posedge i_mclk);
      mismatches++;
      $display("Error watchdog expected done seen timeout");
      results();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      restart(8'h00, 10);
      rd(pfm_pkg::ADDR_DATA, pfm_pkg::RST_DATA, "data");
      rd(pfm_pkg::ADDR_DIR, pfm_pkg::RST_DIR, "dir");
      rd(pfm_pkg::ADDR_PULL, pfm_pkg::RST_PULL, "pull");
      rd(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, pfm_pkg::RST_CONTROL_REGISTER_ZERO, "control_register_zero");
      rd(pfm_pkg::ADDR_ANSEL, pfm_pkg::RST_ANSEL, "ansel");
      rd(3'h6, 8'h00, "unmapped");
      pr(3, 8'h01, "misc");
      pr(4, 8'h09, "osc");
      $display("test reset values done");

      wr(pfm_pkg::ADDR_DIR, 8'hFF);
      wr(pfm_pkg::ADDR_PULL, 8'hFF);
      wr(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, 8'hFF);
      wr(pfm_pkg::ADDR_ANSEL, 8'hFF);
      wr(pfm_pkg::ADDR_PIN, 8'hFF);
      wr(3'h7, 8'hFF);
      rd(pfm_pkg::ADDR_DIR, 8'h78, "dir");
      rd(pfm_pkg::ADDR_PULL, 8'h78, "pull");
      rd(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, 8'h01, "control_register_zero");
      rd(pfm_pkg::ADDR_ANSEL, 8'h01, "ansel");
      rd(pfm_pkg::ADDR_PIN, 8'h00, "pin view");
      rd(3'h7, 8'h00, "unmapped");
      wr(pfm_pkg::ADDR_ANSEL, 8'h00);
      wr(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, 8'h00);
      wr(pfm_pkg::ADDR_DIR, 8'h00);
      wr(pfm_pkg::ADDR_PULL, 8'h50);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(pfm_pkg::ADDR_DATA, lfsr);
         rd(pfm_pkg::ADDR_DATA, lfsr & 8'h78, "data");
         pr(1, {4'h0, lfsr[6:3]}, "out");
      end
      pr(0, 8'h0F, "oe");
      pr(2, 8'h0A, "pull en");
      $display("test outputs and masks done");

      wr(pfm_pkg::ADDR_DIR, 8'h78);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge i_mclk);
         pad_ext <= lfsr[7:3];
         pr(3, {4'h0, lfsr[3], lfsr[4], 2'h1}, "misc");
         rd(pfm_pkg::ADDR_PIN, {lfsr[7:3], 3'h0}, "pin view");
      end
      $display("test inputs done");

      @(posedge i_mclk);
      pad_ext <= 5'h01;
      wr(pfm_pkg::ADDR_DATA, 8'h00);
      wr(pfm_pkg::ADDR_DIR, 8'h00);
      wr(pfm_pkg::ADDR_PULL, 8'h78);
      wr(pfm_pkg::ADDR_ANSEL, 8'h01);
      pr(0, 8'h0E, "oe");
      pr(2, 8'h0E, "pull en");
      pr(3, 8'h19, "misc");
      wr(pfm_pkg::ADDR_DIR, 8'h78);
      pr(2, 8'h0E, "pull en");
      rd(pfm_pkg::ADDR_PIN, 8'h00, "pin view");
      wr(pfm_pkg::ADDR_ANSEL, 8'h00);
      pr(3, 8'h09, "misc");
      rd(pfm_pkg::ADDR_PIN, 8'h08, "pin view");
      $display("test analog select done");

      wr(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, 8'h01);
      @(posedge i_mclk);
      i_pwm <= 1'b1;
      pr(0, 8'h02, "oe");
      pr(1, 8'h02, "out");
      pr(3, 8'h0D, "misc");
      i_pwm <= 1'b0;
      pr(1, 8'h00, "out");
      pr(3, 8'h09, "misc");
      wr(pfm_pkg::ADDR_CONTROL_REGISTER_ZERO, 8'h00);
      pr(0, 8'h00, "oe");
      $display("test pwm done");

      restart(8'h0C, 2);
      @(posedge i_mclk);
      pad_ext <= 5'h03;
      pr(3, 8'h0C, "misc");
      rd(pfm_pkg::ADDR_PIN, 8'h18, "pin view");
      pad_ext <= 5'h13;
      pr(3, 8'h0D, "misc");
      rd(pfm_pkg::ADDR_PIN, 8'h18, "pin view");
      @(posedge i_mclk);
      i_halt <= 1'b1;
      wq.push_back(3);
      pad_ext <= 5'h12;
      pr(3, 8'h05, "misc");
      pad_ext <= 5'h10;
      pr(3, 8'h01, "misc");
      pad_ext <= 5'h00;
      pr(3, 8'h00, "misc");
      i_halt <= 1'b0;
      pad_ext <= 5'h01;
      pr(3, 8'h08, "misc");
      pad_ext <= 5'h00;
      pr(3, 8'h00, "misc");
      compare("wake pending", 8'h00, 8'(wq.size()));
      $display("test reset pin and wake done");

      for (int m = 0; m < 4; m++) begin
         restart(8'(m), 2);
         wr(pfm_pkg::ADDR_DIR, 8'h00);
         wr(pfm_pkg::ADDR_PULL, 8'h78);
         pr(4, osc_exp[m], "osc");
         pr(0, oe_exp[m], "oe");
         pr(2, oe_exp[m], "pull en");
      end
      $display("test oscillator modes done");

      compare("read queue", 8'h00, 8'(rq.size()));
      results();
   end
endmodule
